/* File: design/old_pkg.sv */
// shared constants for the on-state open-load diagnostic block
package old_pkg;
   // channel count and clock
   localparam int          NUM_CH      = 5;
   localparam int          CLK_HZ      = 50000000;
   // timing figures as printed
   localparam int          BULB_DGL_US = 64;
   localparam int          CONV_DGL_US = 2000;
   localparam int          LED_MAX_US  = 2000;
   localparam int          REACT_US    = 100;
   // cycle counts derived from the figures (typical values)
   localparam int          BULB_DGL_CYC = BULB_DGL_US * (CLK_HZ / 1000000);
   localparam int          CONV_DGL_CYC = CONV_DGL_US * (CLK_HZ / 1000000);
   localparam int          LED_MAX_CYC  = LED_MAX_US * (CLK_HZ / 1000000);
   localparam int          REACT_CYC    = REACT_US * (CLK_HZ / 1000000);
   localparam int          CNT_W        = 17;
   // register byte addresses
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_QUICK   = 8'h04;
   localparam logic [7:0]  ADDR_CH0     = 8'h08;
   localparam logic [7:0]  ADDR_RAW     = 8'h1C;
   // control register fields
   localparam int          FLT_SEL_LSB  = 0;
   localparam int          LED_EN_LSB   = 8;
   localparam int          TRIG_BIT     = 16;
   // channel status fields
   localparam int          ST_FAULT_BIT = 0;
   localparam int          ST_GLOBAL_BIT = 1;
   // quick register: global flag position
   localparam int          QK_GLOBAL_BIT = 8;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   // axi responses
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

/* File: design/old_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module old_sync #(
   parameter int W = 5
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } old_sync_st_t;

   old_sync_st_t st_r;
   old_sync_st_t st_nxt;

   // an empty bus has nothing to synchronise
   if (W < 1) begin : g_bad_w
      $error("synchroniser width must be at least 1");
   end

   // a change counts only when stage two and three agree
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.q;
endmodule

/* File: design/old_chan.sv */
// per-channel on-state open-load detector, standard and led modes
`timescale 1ns/1ns
module old_chan (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic out_cmd,
   input  wire logic out_high,
   input  wire logic ol_cur,
   input  wire logic led_cmp_high,
   input  wire logic filt_sel,
   input  wire logic led_en,
   input  wire logic trig_go,
   output logic      gate_on,
   output logic      led_src_on,
   output logic      fault_evt,
   output logic      busy,
   output logic      std_cond
);
   typedef enum logic [2:0] {
      LS_IDLE, LS_EVAL, LS_TRIG_OFF, LS_REACT
   } old_led_st_t;

   typedef struct packed {
      old_led_st_t      led_st;
      logic [16:0]      dgl_cnt;
      logic [16:0]      tmr;
      logic             cmd_d;
      logic             cond;
      logic             evt;
      logic             src;
      logic             gate;
   } old_chan_st_t;

   old_chan_st_t st_r;
   old_chan_st_t st_nxt;
   logic [16:0]  dgl_lim;

   // deglitch length from the filter select bit
   assign dgl_lim = filt_sel ? 17'(old_pkg::CONV_DGL_CYC)
                             : 17'(old_pkg::BULB_DGL_CYC);

   always_comb begin
      st_nxt      = st_r;
      st_nxt.evt  = 1'b0;
      st_nxt.cmd_d = out_cmd;
      st_nxt.gate = out_cmd;
      // standard detection, automatic while the output is on
      if (!out_high || led_en || !ol_cur) begin
         st_nxt.dgl_cnt = '0;
         st_nxt.cond    = 1'b0;
      end else if (st_r.dgl_cnt >= dgl_lim - 17'd1) begin
         st_nxt.cond = 1'b1;
         st_nxt.evt  = 1'b1;
      end else begin
         st_nxt.dgl_cnt = st_r.dgl_cnt + 17'd1;
      end
      // led mode checks the falling edge at switch-off
      case (st_r.led_st)
         LS_IDLE: begin
            st_nxt.src = 1'b0;
            if (led_en && trig_go && out_cmd) begin
               st_nxt.led_st = LS_TRIG_OFF;
               st_nxt.tmr    = '0;
               st_nxt.src    = 1'b1;
               st_nxt.gate   = 1'b0;
            end else if (led_en && st_r.cmd_d && !out_cmd) begin
               st_nxt.led_st = LS_EVAL;
               st_nxt.tmr    = '0;
               st_nxt.src    = 1'b1;
            end
         end
         LS_EVAL: begin
            st_nxt.tmr = st_r.tmr + 17'd1;
            if (!led_cmp_high) begin
               st_nxt.led_st = LS_IDLE;
               st_nxt.src    = 1'b0;
            end else if (out_cmd ||
                  st_r.tmr >= 17'(old_pkg::LED_MAX_CYC) - 17'd1) begin
               st_nxt.evt    = 1'b1;
               st_nxt.led_st = LS_IDLE;
               st_nxt.src    = 1'b0;
            end
         end
         LS_TRIG_OFF: begin
            // output held off for the check; released when done
            st_nxt.gate = 1'b0;
            st_nxt.tmr  = st_r.tmr + 17'd1;
            if (!led_cmp_high ||
                  st_r.tmr >= 17'(old_pkg::LED_MAX_CYC) - 17'd1) begin
               st_nxt.evt    = led_cmp_high;
               st_nxt.led_st = LS_REACT;
               st_nxt.tmr    = '0;
               st_nxt.gate   = out_cmd;
            end
         end
         LS_REACT: begin
            st_nxt.tmr = st_r.tmr + 17'd1;
            if (st_r.tmr >= 17'(old_pkg::REACT_CYC) - 17'd1) begin
               st_nxt.src    = 1'b0;
               st_nxt.led_st = LS_IDLE;
            end
         end
         default: st_nxt.led_st = LS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign gate_on    = st_r.gate;
   assign led_src_on = st_r.src;
   assign fault_evt  = st_r.evt;
   assign std_cond   = st_r.cond;
   assign busy = (st_r.led_st == LS_TRIG_OFF) || (st_r.led_st == LS_REACT);
endmodule

/* File: design/old_top.sv */
// on-state open-load diagnostic top with axi4-lite register slave
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// How it works
// - Each channel without led enable is monitored automatically whenever it is on.
// - A detection sets the quick flag, global flag and channel fault bit.
// - Standard faults clear once gone and read; led faults on the read.
// - A detection never turns the output off.
// - Filter select picks a 64 us or 2.0 ms deglitch per channel.
// - Deglitch counting runs only while the output is high, cleared when low.
// - Per-channel led enable selects low-current led detection.
// - Led mode sources current at switch-off; fault if high at 2 ms or re-on.
// - In pwm the led check starts at each on-time end and lasts up to 2 ms.
// - In pwm the sense source stops at a no-fault decision, at re-on or after 2 ms.
// - A trigger bit runs the led check on all led-enabled fully-on outputs together.
// - The trigger bit clears itself when the triggered check is done.
// - After a fully-on check the output returns; source stops 100 us later.
module old_top (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic [4:0]            out_cmd,
   input  wire logic [4:0]            out_high_pin,
   input  wire logic [4:0]            ol_cur_pin,
   input  wire logic [4:0]            led_cmp_pin,
   output logic      [4:0]            gate_on,
   output logic      [4:0]            led_sense_current_source,
   output logic      [4:0]            channel_quick_flag,
   output logic                       global_openload_flag
);
   localparam int N = old_pkg::NUM_CH;

   typedef struct packed {
      logic [7:0]   awaddr;
      logic         aw_have;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic         w_have;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
      logic [N-1:0] filt_sel;
      logic [N-1:0] led_en;
      logic         trig;
      logic         trig_seen;
      logic [N-1:0] fault;
      logic [N-1:0] fault_led;
      logic [N-1:0] gate;
      logic [N-1:0] src;
      logic         aw_rdy;
      logic         w_rdy;
      logic         ar_rdy;
      logic         glob;
   } old_top_st_t;

   old_top_st_t  st_r;
   old_top_st_t  st_nxt;
   logic [N-1:0] out_high;
   logic [N-1:0] ol_cur;
   logic [N-1:0] led_cmp;
   logic [N-1:0] ch_gate;
   logic [N-1:0] ch_src;
   logic [N-1:0] ch_evt;
   logic [N-1:0] ch_busy;
   logic [N-1:0] ch_cond;
   logic         trig_go;

   // the register map has room for exactly five channels
   if (old_pkg::NUM_CH != 5) begin : g_bad_ch
      $error("channel count must be 5");
   end

   // pins come from the analog side, outside this clock
   old_sync #(.W(3 * N)) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     ({out_high_pin, ol_cur_pin, led_cmp_pin}),
      .dout    ({out_high, ol_cur, led_cmp})
   );

   // one trigger pulse starts all led-enabled channels that are commanded on together
   assign trig_go = st_r.trig && !st_r.trig_seen;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         old_chan u_chan (
            .ref_clk      (ref_clk),
            .rst          (rst),
            .out_cmd      (out_cmd[g]),
            .out_high     (out_high[g]),
            .ol_cur       (ol_cur[g]),
            .led_cmp_high (led_cmp[g]),
            .filt_sel     (st_r.filt_sel[g]),
            .led_en       (st_r.led_en[g]),
            .trig_go      (trig_go),
            .gate_on      (ch_gate[g]),
            .led_src_on   (ch_src[g]),
            .fault_evt    (ch_evt[g]),
            .busy         (ch_busy[g]),
            .std_cond     (ch_cond[g])
         );
      end
   endgenerate

   // register file, bus handshakes and flag latching
   always_comb begin
      logic         wr_fire;
      logic         rd_fire;
      logic [N-1:0] rd_clr;
      wr_fire = 1'b0;
      rd_fire = 1'b0;
      rd_clr  = '0;
      st_nxt  = st_r;
      st_nxt.gate = ch_gate;
      st_nxt.src  = ch_src;
      // self-clear first, so a trigger write in the same cycle wins
      if (st_r.trig && !st_r.trig_seen) begin
         st_nxt.trig_seen = 1'b1;
      end else if (st_r.trig && ~|ch_busy) begin
         st_nxt.trig = 1'b0;
      end
      if (s_axi_awvalid && st_r.aw_rdy) begin
         st_nxt.aw_have = 1'b1;
         st_nxt.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.w_rdy) begin
         st_nxt.w_have = 1'b1;
         st_nxt.wdata  = s_axi_wdata;
         st_nxt.wstrb  = s_axi_wstrb;
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      wr_fire = st_r.aw_have && st_r.w_have && !st_r.bvalid;
      if (wr_fire) begin
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = old_pkg::RESP_OKAY;
         if (st_r.awaddr == old_pkg::ADDR_CTRL) begin
            if (st_r.wstrb[0]) begin
               st_nxt.filt_sel = st_r.wdata[old_pkg::FLT_SEL_LSB +: N];
            end
            if (st_r.wstrb[1]) begin
               st_nxt.led_en = st_r.wdata[old_pkg::LED_EN_LSB +: N];
            end
            if (st_r.wstrb[2] && st_r.wdata[old_pkg::TRIG_BIT]) begin
               st_nxt.trig      = 1'b1;
               st_nxt.trig_seen = 1'b0;
            end
         end else begin
            st_nxt.bresp = old_pkg::RESP_SLVERR;
         end
      end
      rd_fire = s_axi_arvalid && st_r.ar_rdy;
      if (rd_fire) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = old_pkg::RESP_OKAY;
         st_nxt.rdata  = '0;
         case (s_axi_araddr)
            old_pkg::ADDR_CTRL: begin
               st_nxt.rdata[old_pkg::FLT_SEL_LSB +: N] = st_r.filt_sel;
               st_nxt.rdata[old_pkg::LED_EN_LSB +: N]  = st_r.led_en;
               st_nxt.rdata[old_pkg::TRIG_BIT]         = st_r.trig;
            end
            old_pkg::ADDR_QUICK: begin
               st_nxt.rdata[N-1:0] = st_r.fault;
               st_nxt.rdata[old_pkg::QK_GLOBAL_BIT] = |st_r.fault;
            end
            old_pkg::ADDR_RAW: begin
               st_nxt.rdata[N-1:0] = ch_cond;
            end
            default: begin
               st_nxt.rresp = old_pkg::RESP_SLVERR;
               for (int i = 0; i < N; i++) begin
                  if (s_axi_araddr == old_pkg::ADDR_CH0 + 8'(4 * i)) begin
                     st_nxt.rresp = old_pkg::RESP_OKAY;
                     st_nxt.rdata[old_pkg::ST_FAULT_BIT] = st_r.fault[i];
                     st_nxt.rdata[old_pkg::ST_GLOBAL_BIT] = |st_r.fault;
                     rd_clr[i] = 1'b1;
                  end
               end
            end
         endcase
      end
      // latched faults; a new event wins over the read clear
      for (int i = 0; i < N; i++) begin
         if (rd_clr[i] && (st_r.fault_led[i] || !ch_cond[i])) begin
            st_nxt.fault[i]     = 1'b0;
            st_nxt.fault_led[i] = 1'b0;
         end
         if (ch_evt[i]) begin
            st_nxt.fault[i]     = 1'b1;
            st_nxt.fault_led[i] = st_r.led_en[i];
         end
      end
      // readies and global flag kept in flops so every output is registered
      st_nxt.aw_rdy = !st_nxt.aw_have;
      st_nxt.w_rdy  = !st_nxt.w_have;
      st_nxt.ar_rdy = !st_nxt.rvalid;
      st_nxt.glob   = |st_nxt.fault;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = st_r.aw_rdy;
   assign s_axi_wready  = st_r.w_rdy;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = st_r.ar_rdy;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;
   assign gate_on                  = st_r.gate;
   assign led_sense_current_source = st_r.src;
   assign channel_quick_flag       = st_r.fault;
   assign global_openload_flag     = st_r.glob;
endmodule

/* File: tb/old_load_model.sv */
// power stage and load stand-in driving the sense pins
`timescale 1ns/1ns
module old_load_model (
   input  wire logic [4:0] gate_on,
   input  wire logic [4:0] src_on,
   input  wire logic [4:0] open_ld,
   output logic      [4:0] out_high_pin,
   output logic      [4:0] ol_cur_pin,
   output logic      [4:0] led_cmp_pin
);
   // a missing load lets the source hold the node up after switch-off
   assign out_high_pin = gate_on;
   assign ol_cur_pin   = gate_on & open_ld;
   assign led_cmp_pin  = gate_on | (src_on & open_ld);
endmodule

/* File: tb/old_top_monitor.sv */
// concurrent checks on the diagnostic block's ports
`timescale 1ns/1ns
module old_top_monitor (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   input  wire logic [4:0]  out_cmd,
   input  wire logic [4:0]  gate_on,
   input  wire logic [4:0]  led_sense_current_source,
   input  wire logic [4:0]  channel_quick_flag,
   input  wire logic        global_openload_flag
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [4:0]  flag_q, cmd_q, hold;
   logic [3:0]  rd_age;
   logic [17:0] src_cnt;
   logic [11:0] on_cnt [5];
   logic        early;
   // history kept for the checks; rd_age and on_cnt saturate to stay meaningful, src_cnt wraps
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flag_q <= 5'h00;
         cmd_q <= 5'h00;
         rd_age <= 4'hF;
         src_cnt <= 18'h00000;
         for (int i = 0; i < 5; i++)
            on_cnt[i] <= 12'h000;
      end else begin
         flag_q <= channel_quick_flag;
         cmd_q <= out_cmd;
         rd_age <= (s_axi_arvalid && s_axi_arready) ? 4'h0 :
                   (rd_age == 4'hF) ? 4'hF : rd_age + 4'h1;
         src_cnt <= (|led_sense_current_source) ? src_cnt + 18'h1 : 18'h0;
         for (int i = 0; i < 5; i++)
            on_cnt[i] <= !gate_on[i] ? 12'h000 :
                         (&on_cnt[i]) ? on_cnt[i] : on_cnt[i] + 12'h001;
      end
   end
   // a flag rising on a lit channel before the short filter has run
   always_comb begin
      hold = channel_quick_flag & ~flag_q & gate_on & cmd_q;
      early = 1'b0;
      for (int i = 0; i < 5; i++)
         if (channel_quick_flag[i] && !flag_q[i] && gate_on[i] &&
             on_cnt[i] > 12'h008 && on_cnt[i] < 12'hC76)
            early = 1'b1;
   end
   gate_cmd_a: assert property ((gate_on & ~$past(out_cmd, 2)) == 5'h00)
      else $error("gate driven without command");
   fault_keeps_a: assert property (|hold |=>
      (gate_on & $past(hold)) == $past(hold))
      else $error("output dropped on detection");
   global_or_a: assert property (
      global_openload_flag == |channel_quick_flag)
      else $error("global flag disagrees");
   clear_read_a: assert property (
      |(flag_q & ~channel_quick_flag) |-> rd_age < 4'h4)
      else $error("flag cleared without read");
   deglitch_min_a: assert property (!early)
      else $error("flag before deglitch time");
   src_bound_a: assert property (src_cnt < 18'h19B00)
      else $error("sense source on too long");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   unmapped_a: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr > 8'h1C |=> s_axi_rresp == 2'h2)
      else $error("unmapped read not refused");
   cover property (|(channel_quick_flag & ~flag_q));
   cover property (|(flag_q & ~channel_quick_flag));
   cover property ($rose(|led_sense_current_source));
endmodule
bind old_top old_top_monitor old_top_monitor_i (
   .ref_clk(ref_clk), .rst(rst), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .out_cmd(out_cmd), .gate_on(gate_on),
   .led_sense_current_source(led_sense_current_source),
   .channel_quick_flag(channel_quick_flag),
   .global_openload_flag(global_openload_flag));

/* File: tb/old_top_tb.sv */
// self-checking bench for the on-state open-load diagnostic block
`timescale 1ns/1ns
module old_top_tb;
   logic        ref_clk = 1'b0, rst = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        bready = 1'b0, rready = 1'b0, awready, wready, bvalid;
   logic        arready, rvalid, glob;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   logic [4:0]  cmd = 5'h00, open_ld = 5'h00;
   logic [4:0]  gate, src, qflag, hi_pin, cur_pin, cmp_pin;
   logic [33:0] expq [$];
   logic [33:0] e;
   int          err_total = 0, check_count = 0;
   always #10 ref_clk = ~ref_clk;
   old_top old_top_i (
      .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .out_cmd(cmd), .out_high_pin(hi_pin),
      .ol_cur_pin(cur_pin), .led_cmp_pin(cmp_pin), .gate_on(gate),
      .led_sense_current_source(src), .channel_quick_flag(qflag),
      .global_openload_flag(glob));
   old_load_model old_load_model_i (
      .gate_on(gate), .src_on(src), .open_ld(open_ld),
      .out_high_pin(hi_pin), .ol_cur_pin(cur_pin), .led_cmp_pin(cmp_pin));
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      expq.push_back({r, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      bready <= 1'b0;
      if (!bvalid) begin
         err_total++;
         report_and_stop();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] r,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      expq.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      rready <= 1'b0;
      if (!rvalid) begin
         err_total++;
         report_and_stop();
      end
   endtask
   // bus answers checked against the oldest note; error data not defined
   always @(posedge ref_clk) begin
      if ((bvalid && bready) || (rvalid && rready)) begin
         e = (expq.size() > 0) ? expq.pop_front() : 34'h3_FFFF_FFFF;
         if (bvalid)
            chk({bresp, 32'h0}, e);
         else if (e[33:32] == old_pkg::RESP_SLVERR)
            chk({rresp, 32'h0}, e);
         else
            chk({rresp, rdata}, e);
      end
   end
   initial begin
      void'($urandom(32'h1C51BA83));
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      rd(old_pkg::ADDR_CTRL, old_pkg::RESP_OKAY, old_pkg::CTRL_RST);
      rd(old_pkg::ADDR_QUICK, old_pkg::RESP_OKAY, 32'h0);
      rd(8'h20, old_pkg::RESP_SLVERR, 32'h0);
      wr(old_pkg::ADDR_QUICK, 32'h0, old_pkg::RESP_SLVERR);
      // ch0 short filter, ch1 long filter, both loads missing
      wr(old_pkg::ADDR_CTRL, 32'h0000_0002, old_pkg::RESP_OKAY);
      open_ld <= 5'h03;
      // pwm pulses shorter than the filter never latch
      repeat (3) begin
         cmd <= 5'h03;
         repeat ($urandom_range(2900, 500)) @(posedge ref_clk);
         cmd <= 5'h00;
         repeat (20) @(posedge ref_clk);
      end
      chk(34'(qflag), 34'h0);
      cmd <= 5'h03;
      repeat (3000) @(posedge ref_clk);
      chk(34'(qflag), 34'h0);
      repeat (300) @(posedge ref_clk);
      chk(34'({glob, gate, qflag}), 34'h461);
      rd(old_pkg::ADDR_RAW, old_pkg::RESP_OKAY, 32'h1);
      rd(old_pkg::ADDR_CH0, old_pkg::RESP_OKAY, 32'h3);
      rd(old_pkg::ADDR_CH0, old_pkg::RESP_OKAY, 32'h3);
      rd(old_pkg::ADDR_QUICK, old_pkg::RESP_OKAY, 32'h101);
      open_ld <= 5'h00;
      cmd <= 5'h00;
      repeat (10) @(posedge ref_clk);
      rd(old_pkg::ADDR_CH0, old_pkg::RESP_OKAY, 32'h3);
      rd(old_pkg::ADDR_CH0, old_pkg::RESP_OKAY, 32'h0);
      // led mode on ch2: short off-time, fault on the next turn-on
      wr(old_pkg::ADDR_CTRL, 32'h0000_0400, old_pkg::RESP_OKAY);
      open_ld <= 5'h04;
      cmd <= 5'h04;
      repeat (50) @(posedge ref_clk);
      cmd <= 5'h00;
      repeat (20) @(posedge ref_clk);
      chk(34'({gate[2], src[2]}), 34'h1);
      repeat (480) @(posedge ref_clk);
      cmd <= 5'h04;
      repeat (10) @(posedge ref_clk);
      chk(34'(qflag), 34'h04);
      rd(old_pkg::ADDR_CH0 + 8'h08, old_pkg::RESP_OKAY, 32'h3);
      rd(old_pkg::ADDR_CH0 + 8'h08, old_pkg::RESP_OKAY, 32'h0);
      // good led load: source stops at the no-fault decision
      open_ld <= 5'h00;
      cmd <= 5'h00;
      repeat (30) @(posedge ref_clk);
      chk(34'({src, qflag}), 34'h0);
      // fully-on check on ch3 through the trigger bit
      cmd <= 5'h08;
      repeat (10) @(posedge ref_clk);
      wr(old_pkg::ADDR_CTRL, 32'h0001_0800, old_pkg::RESP_OKAY);
      repeat (4000) @(posedge ref_clk);
      chk(34'({gate[3], src[3]}), 34'h3);
      repeat (1200) @(posedge ref_clk);
      chk(34'({gate[3], src[3]}), 34'h2);
      rd(old_pkg::ADDR_CTRL, old_pkg::RESP_OKAY, 32'h0000_0800);
      chk(34'(qflag), 34'h0);
      repeat (5) @(posedge ref_clk);
      report_and_stop();
   end
endmodule
